//--- pers_pkg.sv
/*
 * Shared constants for the power-enable / reset sequencer: host register map,
 * sequencing times and device state encodings.
 * Assumes a single 20 MHz clock on both ends.
 */
package pers_pkg;
	localparam int CLK_HZ = 20000000;
	localparam int RESET_DELAY_MS = 5;
	localparam int RESET_MARGIN_MS = 1;
	localparam int RESET_DELAY_CYC = (RESET_DELAY_MS + RESET_MARGIN_MS) * (CLK_HZ / 1000);
	localparam int NUM_PADS = 8;

	// host register map, byte addresses
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] CNT_OFS = 8'h08;
	localparam int CTRL_ON_BIT = 0;
	localparam int CTRL_SUPPLY_BIT = 1;
	localparam int STAT_EN_BIT = 0;
	localparam int STAT_RST_BIT = 1;
	localparam int STAT_SUPPLY_BIT = 2;
	localparam int STAT_ST_LSB = 4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	typedef enum logic [1:0] {
		PERS_OFF,
		PERS_WAIT,
		PERS_RUN
	} pers_host_state_type;

	typedef enum logic [2:0] {
		PERS_PD,
		PERS_POR,
		PERS_DEFAULT,
		PERS_DOZE,
		PERS_ACTIVE
	} pers_dev_state_type;

	typedef enum logic [1:0] {
		PERS_RADIO_IDLE,
		PERS_RADIO_TX,
		PERS_RADIO_RX
	} pers_radio_type;
endpackage : pers_pkg

//--- pers_link_if.sv
/*
 * Link between host sequencer and the device: supply, enable and reset pins.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/1ps
interface pers_link_if;
	logic io_supply;
	logic core_enable;
	logic hard_reset_low;

	modport host (
		output io_supply,
		output core_enable,
		output hard_reset_low
	);

	modport device (
		input io_supply,
		input core_enable,
		input hard_reset_low
	);
endinterface : pers_link_if

//--- pers_device.sv
/*
 * Device end: pad state control, DC/DC enable and operating state report.
 * Assumes link pins are always driven by the host and synchronous to hclk.
 */
`timescale 1ns/1ps
module pers_device #(
	parameter int NUM_PADS = pers_pkg::NUM_PADS
) (
	input wire logic hclk,
	input wire logic hresetn,
	pers_link_if.device link,
	input wire logic pads_configured,
	input wire logic [NUM_PADS-1:0] fw_out_en,
	input wire logic [NUM_PADS-1:0] fw_pull_en,
	input wire logic [1:0] wlan_mode,
	input wire logic [1:0] srr_mode,
	output logic dcdc_on,
	output logic [NUM_PADS-1:0] pad_oe_n,
	output logic [NUM_PADS-1:0] pad_in_en,
	output logic [NUM_PADS-1:0] pad_pull_en,
	output logic [2:0] dev_state,
	output logic [1:0] wlan_state,
	output logic [1:0] srr_state
);
	if (NUM_PADS < 1) begin : g_bad_pads
		$error("NUM_PADS must be at least 1");
	end

	logic on_w;
	logic cfg_q;
	pers_pkg::pers_dev_state_type st_d;

	// mode code 3 is no radio activity and counts as idle
	function automatic logic radio_busy(input logic [1:0] mode);
		return mode == 2'(pers_pkg::PERS_RADIO_TX) || mode == 2'(pers_pkg::PERS_RADIO_RX);
	endfunction : radio_busy

	assign on_w = link.io_supply && link.core_enable && link.hard_reset_low;

	// configuration is lost whenever the core leaves reset-free operation
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_q <= 1'b0;
		end else if (!on_w) begin
			cfg_q <= 1'b0;
		end else if (pads_configured) begin
			cfg_q <= 1'b1;
		end
	end

	always_comb begin
		if (!link.io_supply || !link.core_enable) begin
			st_d = pers_pkg::PERS_PD; // R06
		end else if (!link.hard_reset_low) begin
			st_d = pers_pkg::PERS_POR;
		end else if (!cfg_q) begin
			st_d = pers_pkg::PERS_DEFAULT;
		end else if (!radio_busy(wlan_mode) && !radio_busy(srr_mode)) begin
			st_d = pers_pkg::PERS_DOZE; // R13
		end else begin
			st_d = pers_pkg::PERS_ACTIVE; // R07
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dcdc_on <= 1'b0;
		end else begin
			dcdc_on <= link.io_supply && link.core_enable; // R08
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dev_state <= 3'(pers_pkg::PERS_PD);
		end else begin
			dev_state <= 3'(st_d);
		end
	end

	// radios run independently; forced idle outside the active states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wlan_state <= 2'(pers_pkg::PERS_RADIO_IDLE);
			srr_state <= 2'(pers_pkg::PERS_RADIO_IDLE);
		end else if (on_w && cfg_q) begin
			wlan_state <= radio_busy(wlan_mode) ? wlan_mode : 2'(pers_pkg::PERS_RADIO_IDLE); // R14
			srr_state <= radio_busy(srr_mode) ? srr_mode : 2'(pers_pkg::PERS_RADIO_IDLE); // R14
		end else begin
			wlan_state <= 2'(pers_pkg::PERS_RADIO_IDLE);
			srr_state <= 2'(pers_pkg::PERS_RADIO_IDLE);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pad_oe_n <= '1;
			pad_in_en <= '0;
			pad_pull_en <= '0;
		end else begin
			case (st_d)
				pers_pkg::PERS_PD: begin
					pad_oe_n <= '1; // R09
					pad_in_en <= '0;
					pad_pull_en <= '0;
				end
				pers_pkg::PERS_POR: begin
					pad_oe_n <= '1; // R10
					pad_in_en <= '0;
					pad_pull_en <= '1;
				end
				pers_pkg::PERS_DEFAULT: begin
					pad_oe_n <= '1; // R11
					pad_in_en <= '1;
					pad_pull_en <= '1;
				end
				pers_pkg::PERS_DOZE, pers_pkg::PERS_ACTIVE: begin
					pad_oe_n <= ~fw_out_en; // R12
					pad_in_en <= ~fw_out_en; // R12
					pad_pull_en <= fw_pull_en;
				end
				default: begin
					pad_oe_n <= '1;
					pad_in_en <= '0;
					pad_pull_en <= '0;
				end
			endcase
		end
	end
endmodule : pers_device

//--- pers_host.sv
/*
 * Host sequencer: AHB-Lite slave with control/status registers, driving the
 * supply, core enable and reset pins in the required order.
 * Assumes a single AHB-Lite master, word transfers only, 20 MHz hclk.
 */
// How it works
// R01: reset held low 5 ms after enable
// R02: enable and reset drop together
// R03: both pins always driven to a level
// R04: enable rises only with supply present
// R05: enable and reset low before supply drops
// R06: both low puts device into power-down
// R07: enable held high while operating
// R08: device DC/DC follows enable
// R09: power-down pads all off
// R10: reset phase pads pulled only
// R11: after reset pads input and pull
// R12: configured pads follow firmware, input opposite
// R13: doze when powered but radios idle
// R14: two radios active independently
// R15: host counter times reset release with margin
`timescale 1ns/1ps
module pers_host #(
	parameter int RESET_DELAY_CYC = pers_pkg::RESET_DELAY_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	pers_link_if.host link
);
	// a zero delay would wrap the expiry compare to all ones and hold reset low for about 2^32 cycles
	if (RESET_DELAY_CYC < 1) begin : g_bad_delay
		$error("RESET_DELAY_CYC must be at least 1");
	end

	pers_pkg::pers_host_state_type st_q;
	logic [31:0] ctrl_q;
	logic [31:0] cnt_q;
	logic wr_q;
	logic [7:0] addr_q;
	logic sup_q;
	logic en_q;
	logic rst_n_q;
	logic want_on;
	logic want_sup;
	logic start_w;
	logic abort_w;
	logic expire_w;

	// address phase of a transfer that this slave must answer
	function automatic logic addr_phase(
		input logic sel,
		input logic rdy,
		input logic [1:0] trans
	);
		return sel && rdy && trans[1];
	endfunction : addr_phase

	// status word built from the field positions of the map
	function automatic logic [31:0] status_word(
		input logic en,
		input logic rst_n,
		input logic sup,
		input logic [1:0] st
	);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[pers_pkg::STAT_EN_BIT] = en;
		w[pers_pkg::STAT_RST_BIT] = rst_n;
		w[pers_pkg::STAT_SUPPLY_BIT] = sup;
		w[pers_pkg::STAT_ST_LSB +: 2] = st;
		return w;
	endfunction : status_word

	assign want_on = ctrl_q[pers_pkg::CTRL_ON_BIT];
	assign want_sup = ctrl_q[pers_pkg::CTRL_SUPPLY_BIT];

	// enable waits one cycle behind the supply pin
	assign start_w = want_on && want_sup && sup_q;
	assign abort_w = !want_on || !want_sup;
	assign expire_w = cnt_q >= 32'(RESET_DELAY_CYC - 1);

	// zero-wait slave, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			addr_q <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_q <= addr_phase(hsel, hready, htrans) && hwrite;
			addr_q <= haddr[7:0];
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= pers_pkg::CTRL_RESET;
		end else if (wr_q && addr_q == pers_pkg::CTRL_OFS) begin
			ctrl_q <= {30'h0, hwdata[1:0]};
		end
	end

	// read data registered in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_phase(hsel, hready, htrans) && !hwrite) begin
			case (haddr[7:0])
				pers_pkg::CTRL_OFS: hrdata <= ctrl_q;
				pers_pkg::STAT_OFS: hrdata <= status_word(en_q, rst_n_q, sup_q, st_q);
				pers_pkg::CNT_OFS: hrdata <= cnt_q;
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// sequencer state: off, waiting out the reset delay, running
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= pers_pkg::PERS_OFF;
		end else begin
			case (st_q)
				pers_pkg::PERS_OFF: begin
					if (start_w) begin
						st_q <= pers_pkg::PERS_WAIT;
					end
				end
				pers_pkg::PERS_WAIT: begin
					if (abort_w) begin
						st_q <= pers_pkg::PERS_OFF;
					end else if (expire_w) begin
						st_q <= pers_pkg::PERS_RUN;
					end
				end
				pers_pkg::PERS_RUN: begin
					if (abort_w) begin
						st_q <= pers_pkg::PERS_OFF;
					end
				end
				default: begin
					st_q <= pers_pkg::PERS_OFF;
				end
			endcase
		end
	end

	// own-clock delay count; the margin is already in the delay figure
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 32'h0000_0000;
		end else if (st_q == pers_pkg::PERS_OFF) begin
			cnt_q <= 32'h0000_0000;
		end else if (st_q == pers_pkg::PERS_WAIT && !abort_w && !expire_w) begin
			cnt_q <= cnt_q + 32'h0000_0001; // R15
		end
	end

	// a pin is never left undriven, every state has a level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_q <= 1'b0; // R03
		end else if (abort_w) begin
			en_q <= 1'b0; // R02
		end else if (st_q == pers_pkg::PERS_OFF) begin
			en_q <= start_w; // R04
		end else if (st_q == pers_pkg::PERS_WAIT || st_q == pers_pkg::PERS_RUN) begin
			en_q <= 1'b1; // R07
		end else begin
			en_q <= 1'b0;
		end
	end

	// drops on the same edge as enable, rises only when the count runs out
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rst_n_q <= 1'b0; // R03
		end else if (abort_w) begin
			rst_n_q <= 1'b0; // R06
		end else if (st_q == pers_pkg::PERS_WAIT && expire_w) begin
			rst_n_q <= 1'b1; // R01
		end else if (st_q != pers_pkg::PERS_RUN) begin
			rst_n_q <= 1'b0;
		end
	end

	// supply drops only once enable and reset are already low
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sup_q <= 1'b0;
		end else if (want_sup) begin
			sup_q <= 1'b1;
		end else if (!en_q && !rst_n_q) begin
			sup_q <= 1'b0; // R05
		end
	end

	assign link.io_supply = sup_q;
	assign link.core_enable = en_q;
	assign link.hard_reset_low = rst_n_q;
endmodule : pers_host

//--- pers_link_props.sv
/* Checker for the supply, enable and reset pins between host and device.
 Assumes hclk, hresetn and the pins come from the bench top. */
`timescale 1ns/1ps
module pers_link_props #(
	parameter int RESET_DELAY_CYC = pers_pkg::RESET_DELAY_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic io_supply,
	input wire logic core_enable,
	input wire logic hard_reset_low
);
	int cnt_q;
	// cycles with enable up, restarts whenever it drops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 0;
		end else begin
			cnt_q <= core_enable ? cnt_q + 1 : 0;
		end
	end
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	rel_early_a: assert property ($rose(hard_reset_low) |-> cnt_q >= RESET_DELAY_CYC)
		else $error("reset released too soon");
	hold_low_a: assert property ($rose(core_enable) |-> !hard_reset_low [*8])
		else $error("reset not held after enable");
	rel_bound_a: assert property (core_enable && !hard_reset_low |-> cnt_q <= RESET_DELAY_CYC)
		else $error("reset release overdue");
	drop_pair_a: assert property ($fell(core_enable) |-> !hard_reset_low)
		else $error("enable fell alone");
	rst_pair_a: assert property ($fell(hard_reset_low) |-> !core_enable)
		else $error("reset fell alone");
	en_supply_a: assert property ($rose(core_enable) |-> $past(io_supply))
		else $error("enable before supply");
	supply_last_a: assert property ($fell(io_supply) |-> !$past(core_enable) && !$past(hard_reset_low))
		else $error("supply dropped under live pins");
	run_supply_a: assert property (hard_reset_low |-> core_enable && io_supply)
		else $error("running without enable or supply");
	up_c: cover property ($rose(hard_reset_low));
	down_c: cover property ($fell(core_enable) && $past(hard_reset_low));
	off_c: cover property ($fell(io_supply));
endmodule : pers_link_props

//--- power_enable_reset_sequencer_tb.sv
/* Bench joining host and device over the link, driving the host by AHB-Lite.
 Assumes a 20-cycle reset delay instead of the full count. */
`timescale 1ns/1ps
module power_enable_reset_sequencer_tb;
	localparam int D = 20;
	localparam logic [31:0] PD = 32'h00FF_0000;
	typedef struct packed {logic [1:0] ctrl; logic [31:0] stat; logic [31:0] dev;} pers_row_type;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, pads_configured = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0] htrans = 0, wlan_mode = 0, srr_mode = 0;
	logic [2:0] hsize = 3'h2;
	logic [7:0] fw_out_en = 0, fw_pull_en = 0;
	logic hready, hreadyout, hresp, dcdc_on;
	logic [7:0] pad_oe_n, pad_in_en, pad_pull_en;
	logic [2:0] dev_state;
	logic [1:0] wlan_state, srr_state;
	wire logic [31:0] dv = {dcdc_on, dev_state, wlan_state, srr_state, pad_oe_n, pad_in_en, pad_pull_en};
	int bad_count = 0, comparisons = 0;
	pers_row_type rows [4] = '{'{2'h2, 32'h4, PD}, '{2'h3, 32'h27, 32'hA0FF_FFFF}, '{2'h2, 32'h4, PD}, '{2'h0, 32'h0, PD}};
	pers_link_if link ();
	assign hready = hreadyout;
	pers_host #(.RESET_DELAY_CYC(D)) i_pers_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .link(link.host));
	pers_device i_pers_device (.hclk(hclk), .hresetn(hresetn), .link(link.device), .pads_configured(pads_configured),
		.fw_out_en(fw_out_en), .fw_pull_en(fw_pull_en), .wlan_mode(wlan_mode), .srr_mode(srr_mode), .dcdc_on(dcdc_on),
		.pad_oe_n(pad_oe_n), .pad_in_en(pad_in_en), .pad_pull_en(pad_pull_en), .dev_state(dev_state),
		.wlan_state(wlan_state), .srr_state(srr_state));
	pers_link_props #(.RESET_DELAY_CYC(D)) i_pers_link_props (.hclk(hclk), .hresetn(hresetn),
		.io_supply(link.io_supply), .core_enable(link.core_enable), .hard_reset_low(link.hard_reset_low));
	always #25 hclk = ~hclk;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// entered just after an edge; rd holds read data on return
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic end_of_test;
		$display("checks %0d bad %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (rows[i]) begin
			bus(1'b1, 8'h00, {30'h0, rows[i].ctrl});
			repeat (D + 8) @(posedge hclk);
			bus(1'b0, 8'h04, 32'h0);
			chk(rd, rows[i].stat);
			chk({30'h0, hreadyout, hresp}, 32'h2);
			chk(dv, rows[i].dev);
			chk({29'h0, link.io_supply, link.core_enable, link.hard_reset_low},
				{29'h0, rows[i].stat[2], rows[i].stat[0], rows[i].stat[1]});
		end
		bus(1'b1, 8'h00, 32'h3);
		repeat (8) @(posedge hclk);
		bus(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h15);
		chk(dv, 32'h90FF_00FF);
		repeat (D) @(posedge hclk);
		pads_configured <= 1'b1;
		fw_out_en <= 8'hA5;
		fw_pull_en <= 8'h3C;
		srr_mode <= 2'h3;
		repeat (3) @(posedge hclk);
		chk(dv, 32'hB05A_5A3C);
		wlan_mode <= 2'h1;
		srr_mode <= 2'h2;
		repeat (3) @(posedge hclk);
		chk(dv, 32'hC65A_5A3C);
		wlan_mode <= 2'h2;
		srr_mode <= 2'h3;
		repeat (3) @(posedge hclk);
		chk(dv, 32'hC85A_5A3C);
		// power-down, then a power-up cut short in mid-wait
		bus(1'b1, 8'h00, 32'h0);
		bus(1'b1, 8'h00, 32'h3);
		repeat (5) @(posedge hclk);
		bus(1'b1, 8'h00, 32'h0);
		repeat (D) @(posedge hclk);
		chk(dv, PD);
		bus(1'b1, 8'h0C, 32'h3);
		bus(1'b0, 8'h0C, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, 8'h00, 32'h3);
		repeat (D + 8) @(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		chk(dv, PD);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0);
		end_of_test();
	end
	// whole run is a few hundred cycles
	initial begin
		repeat (2000) @(posedge hclk);
		bad_count++;
		end_of_test();
	end
endmodule : power_enable_reset_sequencer_tb
